// ### lfr_pkg.sv
/*
 * Shared constants for the low-frequency receiver control register pair:
 * register indices, field positions, reset values and bus codes.
 * Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
 */
package lfr_pkg;
	// Register indices; the byte address is four times the index.
	localparam int unsigned LFR_ADDR_W = 8;
	localparam logic [5:0] IDX_FILT = 6'h24;
	localparam logic [5:0] IDX_CNT = 6'h25;
	localparam logic [5:0] IDX_AUX = 6'h26;
	localparam logic [5:0] IDX_STAT = 6'h27;
	localparam logic [5:0] IDX_MASK = 6'h28;
	// Reset values.
	localparam logic [7:0] FILT_RST = 8'hc4;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [3:0] AUX_RST = 4'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// Field positions of the filter/polarity register.
	localparam int unsigned DB_LSB = 6;
	localparam int unsigned FT_BIT = 5;
	localparam int unsigned FO_BIT = 4;
	localparam int unsigned POL_BIT = 3;
	// Writable bits of the carrier-count register; the upper nibble is reserved.
	localparam logic [7:0] CNT_WMASK = 8'h0f;
	// Auxiliary control bits.
	localparam int unsigned PAGE_BIT = 0;
	localparam int unsigned TOG_BIT = 1;
	localparam int unsigned AZS_LSB = 2;
	// Interrupt status bits.
	localparam int unsigned ST_CD = 0;
	localparam int unsigned ST_AZ = 1;
	localparam int unsigned IRQ_W = 2;
	// Slicer deadband in millivolts per select code.
	localparam logic [5:0] DB_MV0 = 6'h14;
	localparam logic [5:0] DB_MV1 = 6'h28;
	localparam logic [5:0] DB_MV2 = 6'h32;
	localparam logic [5:0] DB_MV3 = 6'h1e;
	// Auto-zero trigger select codes.
	localparam logic [1:0] AZS_PLAIN = 2'h0;
	localparam logic [1:0] AZS_RAND = 2'h1;
	localparam logic [1:0] AZS_LOW = 2'h2;
	localparam logic [1:0] AZS_HIGH = 2'h3;
	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Write channel state.
	typedef enum logic [1:0] {
		LFR_WR_IDLE = 2'b01,
		LFR_WR_RESP = 2'b10
	} lfr_wr_e;
endpackage : lfr_pkg

// ### lfr_carrier_val.sv
/*
 * Consecutive-carrier validation counter.
 * Assumes one sample_valid pulse per carrier-detect ON-time sample, with
 * sample_hit already qualified against the sample threshold.
 */
`timescale 1ns/100ps
module lfr_carrier_val import lfr_pkg::*; #(
	parameter int unsigned TGT_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sample_valid,
	input wire logic sample_hit,
	input wire logic data_mode,
	input wire logic toggle_mode,
	input wire logic [TGT_W-1:0] run_target,
	output logic validated
);
	logic [TGT_W:0] run_q;

	// Count consecutive hits; the count holds once it has reached target plus one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= '0;
			validated <= 1'b0;
		end else begin
			validated <= 1'b0;
			if (data_mode) begin
				run_q <= '0;
			end else if (toggle_mode) begin
				run_q <= '0;
				validated <= sample_valid && sample_hit;
			end else if (sample_valid) begin
				if (!sample_hit) begin
					run_q <= '0;
				end else if (run_q <= {1'b0, run_target}) begin
					run_q <= run_q + 1'b1;
					validated <= (run_q == {1'b0, run_target});
				end
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	run_reach_a: assert property (
		sample_valid && sample_hit && !data_mode && !toggle_mode
		&& run_q == {1'b0, run_target} |=> validated && run_q == $past(run_q) + 1'b1)
		else $error("count reached target plus one without validation");
	miss_clear_a: assert property (
		sample_valid && !sample_hit |=> run_q == '0 && !validated)
		else $error("missed sample did not clear the count");
	data_zero_a: assert property (
		data_mode |=> run_q == '0 && !validated)
		else $error("count not zero in data mode");
	toggle_off_a: assert property (
		toggle_mode && !data_mode |=> run_q == '0)
		else $error("counter ran in toggle mode");
	cov_validate_c: cover property (validated && !toggle_mode);
endmodule : lfr_carrier_val

// ### lfr_az_gap.sv
/*
 * Auto-zero request spacing on received data edges.
 * Assumes data_edge is a one-cycle pulse per demodulated data edge and
 * data_level is the demodulated data state.
 */
`timescale 1ns/100ps
module lfr_az_gap import lfr_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic data_mode,
	input wire logic data_edge,
	input wire logic data_level,
	input wire logic [1:0] trig_sel,
	input wire logic [2:0] gap,
	output logic az_req
);
	logic [3:0] cnt_q;
	logic [3:0] lfsr_q;
	logic [1:0] jit_q;
	logic [4:0] lhs;
	logic [4:0] rhs;
	logic lvl_ok;
	logic fire;

	// Random mode compares count+1 against gap+jitter, i.e. gap plus -1, 0 or +1.
	always_comb begin
		lhs = {1'b0, cnt_q} + ((trig_sel == AZS_RAND) ? 5'h01 : 5'h00);
		rhs = {2'h0, gap} + ((trig_sel == AZS_RAND) ? {3'h0, jit_q} : 5'h00);
		lvl_ok = (trig_sel == AZS_LOW) ? !data_level :
			(trig_sel == AZS_HIGH) ? data_level : 1'b1;
		fire = data_mode && !az_req && cnt_q != 4'h0 && lhs >= rhs && lvl_ok;
	end

	// Edge count; saturates so a long wait for the data level cannot wrap it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 4'h0;
			az_req <= 1'b0;
		end else begin
			az_req <= fire;
			if (!data_mode || fire) begin
				cnt_q <= 4'h0;
			end else if (data_edge && cnt_q != 4'hf) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// Free-running LFSR; a new jitter of 0, 1 or 2 is drawn at each request.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lfsr_q <= 4'h1;
			jit_q <= 2'h1;
		end else begin
			lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
			if (fire) begin
				jit_q <= (lfsr_q[1:0] == 2'h3) ? 2'h1 : lfsr_q[1:0];
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	gap_plain_a: assert property (
		az_req && $past(trig_sel) == AZS_PLAIN |-> $past(cnt_q) >= {1'b0, $past(gap)}
		&& $past(data_mode)) else $error("auto-zero request before edge spacing");
	level_qual_a: assert property (
		az_req && $past(trig_sel) == AZS_HIGH |-> $past(data_level))
		else $error("auto-zero request with wrong data level");
	az_restart_a: assert property (
		az_req |-> cnt_q == 4'h0 ##1 !az_req)
		else $error("edge count not restarted after request");
endmodule : lfr_az_gap

// ### lfr_ctrl_ba.sv
/*
 * Paged filter/polarity and carrier-count control registers of the
 * low-frequency receiver, with an AXI4-Lite slave, interrupt status and
 * the decode logic those registers steer.
 * Assumes receiver status and events arrive synchronous to aclk.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
// Notes on behaviour
// - The two control registers sit at indices 24h and 25h and are reachable only while the page select bit is one.
// - Bits 7-6 choose the slicer deadband: 20, 40, 50 or 30 mV.
// - Bits 5-4 choose low-pass filtering for 00/01, bi-phase low offset for 10, bi-phase high offset for 11.
// - Bit 3 clear decodes a falling mid-bit edge as zero; set reverses the mapping.
// - The polarity setting has no effect outside data decoding.
// - Reset clears the polarity bit.
// - Bits 2-0 give the least number of data edges between two auto-zero requests.
// - The carrier flag sets when consecutive carrier samples reach the count field plus one.
// - Only consecutive carrier samples count; a sample without carrier zeroes the count.
// - In data mode the validation count is treated as zero.
// - The first carrier validation starts the receive chain.
// - Toggle mode disables the consecutive count.
// - The trigger select qualifies auto-zero requests by plain, randomised or data-level rules.
`timescale 1ns/100ps
module lfr_ctrl_ba import lfr_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [LFR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [LFR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_data_mode,
	input wire logic carrier_sample_valid,
	input wire logic carrier_sample_hit,
	input wire logic midbit_valid,
	input wire logic midbit_rising,
	input wire logic data_edge,
	input wire logic data_level,
	output logic [1:0] slicer_deadband,
	output logic [5:0] deadband_mv,
	output logic filter_type_sel,
	output logic filter_offset_sel,
	output logic [2:0] edge_gap_count,
	output logic decoded_valid,
	output logic decoded_bit,
	output logic auto_zero_req,
	output logic rx_chain_start,
	output logic carrier_detect_flag,
	output logic irq
);
	lfr_wr_e wr_st_q;
	logic [5:0] aw_idx_q;
	logic [7:0] wdata_q;
	logic wlane_q;
	logic [7:0] filt_q;
	logic [7:0] cnt_q;
	logic [3:0] aux_q;
	logic [IRQ_W-1:0] stat_q;
	logic [IRQ_W-1:0] mask_q;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] w1c;
	logic wr_go;
	logic validated;
	logic page;

	// The full six-bit index is decoded; byte offsets are dropped.
	function automatic logic idx_ok(input logic [5:0] idx, input logic pg);
		idx_ok = ((idx == IDX_FILT || idx == IDX_CNT) && pg)
			|| idx == IDX_AUX || idx == IDX_STAT || idx == IDX_MASK;
	endfunction : idx_ok

	// Readback mux; unused bits above each register read as zero.
	function automatic logic [31:0] rd_val(input logic [5:0] idx);
		rd_val = 32'h0000_0000;
		case (idx)
			IDX_FILT: rd_val = {24'h00_0000, filt_q};
			IDX_CNT: rd_val = {24'h00_0000, cnt_q};
			IDX_AUX: rd_val = {28'h000_0000, aux_q};
			IDX_STAT: rd_val = {30'h0000_0000, stat_q};
			IDX_MASK: rd_val = {30'h0000_0000, mask_q};
			default: rd_val = 32'h0000_0000;
		endcase
	endfunction : rd_val

	assign page = aux_q[PAGE_BIT];
	assign wr_go = (wr_st_q == LFR_WR_IDLE) && !s_axi_awready && !s_axi_wready;
	assign s_axi_bvalid = wr_st_q[1];

	// Write channel: address and data are taken in either order, then one response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_st_q <= LFR_WR_IDLE;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bresp <= RESP_OKAY;
			aw_idx_q <= 6'h00;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_idx_q <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			unique case (wr_st_q)
				LFR_WR_IDLE: begin
					if (wr_go) begin
						wr_st_q <= LFR_WR_RESP;
						s_axi_bresp <= idx_ok(aw_idx_q, page) ? RESP_OKAY : RESP_SLVERR;
					end
				end
				LFR_WR_RESP: begin
					if (s_axi_bready) begin
						wr_st_q <= LFR_WR_IDLE;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
					end
				end
			endcase
		end
	end

	// Read channel: one read at a time, answered one cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (idx_ok(s_axi_araddr[7:2], page)) begin
				s_axi_rdata <= rd_val(s_axi_araddr[7:2]);
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Control registers; a paged register only takes a write while the page is open.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_q <= FILT_RST;
			cnt_q <= CNT_RST;
			aux_q <= AUX_RST;
			mask_q <= MASK_RST;
		end else if (wr_go && wlane_q) begin
			if (aw_idx_q == IDX_FILT && page) begin
				filt_q <= wdata_q;
			end
			if (aw_idx_q == IDX_CNT && page) begin
				cnt_q <= wdata_q & CNT_WMASK;
			end
			if (aw_idx_q == IDX_AUX) begin
				aux_q <= wdata_q[3:0];
			end
			if (aw_idx_q == IDX_MASK) begin
				mask_q <= wdata_q[IRQ_W-1:0];
			end
		end
	end

	assign slicer_deadband = filt_q[DB_LSB+1:DB_LSB];
	assign filter_type_sel = filt_q[FT_BIT];
	assign filter_offset_sel = filt_q[FO_BIT];
	assign edge_gap_count = filt_q[2:0];

	// Deadband in millivolts; the code 11 default is the second smallest value, not the largest.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deadband_mv <= DB_MV3;
		end else begin
			unique case (filt_q[DB_LSB+1:DB_LSB])
				2'h0: deadband_mv <= DB_MV0;
				2'h1: deadband_mv <= DB_MV1;
				2'h2: deadband_mv <= DB_MV2;
				2'h3: deadband_mv <= DB_MV3;
			endcase
		end
	end

	// Mid-bit decode; outside data mode nothing is decoded, so polarity is moot.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decoded_valid <= 1'b0;
			decoded_bit <= 1'b0;
		end else begin
			decoded_valid <= midbit_valid && rx_data_mode;
			if (midbit_valid && rx_data_mode) begin
				decoded_bit <= midbit_rising ^ filt_q[POL_BIT];
			end
		end
	end

	lfr_carrier_val #(
		.TGT_W(4)
	) u_carrier (
		.aclk(aclk),
		.aresetn(aresetn),
		.sample_valid(carrier_sample_valid),
		.sample_hit(carrier_sample_hit),
		.data_mode(rx_data_mode),
		.toggle_mode(aux_q[TOG_BIT]),
		.run_target(cnt_q[3:0]),
		.validated(validated)
	);

	lfr_az_gap u_az (
		.aclk(aclk),
		.aresetn(aresetn),
		.data_mode(rx_data_mode),
		.data_edge(data_edge),
		.data_level(data_level),
		.trig_sel(aux_q[AZS_LSB+1:AZS_LSB]),
		.gap(filt_q[2:0]),
		.az_req(auto_zero_req)
	);

	assign ev[ST_CD] = validated;
	assign ev[ST_AZ] = auto_zero_req;
	assign w1c = (wr_go && wlane_q && aw_idx_q == IDX_STAT) ? wdata_q[IRQ_W-1:0] : '0;
	assign carrier_detect_flag = stat_q[ST_CD];

	// Sticky status; a new event in the clearing cycle keeps its bit set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~w1c) | ev;
		end
	end

	// Chain start fires only on a validation that finds the flag clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_chain_start <= 1'b0;
		end else begin
			rx_chain_start <= validated && !stat_q[ST_CD];
		end
	end

	// Interrupt follows the status one cycle later to keep the output registered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	page_closed_a: assert property (
		wr_go && aw_idx_q == IDX_FILT && !page |=> s_axi_bresp == RESP_SLVERR
		&& $stable(filt_q)) else $error("paged write accepted with page closed");
	deadband_map_a: assert property (
		filt_q[7:6] == 2'h3 ##1 filt_q[7:6] == 2'h3 |-> deadband_mv == DB_MV3)
		else $error("deadband code 11 not 30 mV");
	// Codes 00 and 10 are checked too, so a swapped table entry cannot hide behind the default.
	deadband_low_a: assert property (
		filt_q[7:6] == 2'h0 ##1 filt_q[7:6] == 2'h0 |-> deadband_mv == DB_MV0)
		else $error("deadband code 00 not 20 mV");
	deadband_wide_a: assert property (
		filt_q[7:6] == 2'h2 ##1 filt_q[7:6] == 2'h2 |-> deadband_mv == DB_MV2)
		else $error("deadband code 10 not 50 mV");
	edge_invert_a: assert property (
		midbit_valid && rx_data_mode && midbit_rising && filt_q[POL_BIT]
		|=> decoded_valid && !decoded_bit) else $error("rising edge not zero with polarity set");
	edge_sense_a: assert property (
		midbit_valid && rx_data_mode && !midbit_rising && !filt_q[POL_BIT]
		|=> decoded_valid && !decoded_bit) else $error("falling edge not zero");
	carrier_mode_a: assert property (
		!rx_data_mode |=> !decoded_valid) else $error("decode outside data mode");
	pol_reset_a: assert property (
		$rose(aresetn) |-> filt_q == FILT_RST) else $error("polarity not cleared");
	chain_start_a: assert property (
		rx_chain_start |-> carrier_detect_flag && !$past(carrier_detect_flag))
		else $error("chain start not on first validation");
	reserved_zero_a: assert property (
		cnt_q[7:4] == 4'h0) else $error("reserved count bits not zero");
	set_wins_a: assert property (
		validated |=> carrier_detect_flag) else $error("carrier flag lost");
	cov_write_c: cover property (wr_go && aw_idx_q == IDX_CNT && page);
	cov_decode_c: cover property (decoded_valid && decoded_bit);
	cov_az_c: cover property (auto_zero_req ##[1:20] auto_zero_req);
	cov_start_c: cover property (rx_chain_start);
endmodule : lfr_ctrl_ba

// ### lfr_lf_src.sv
/*
 * Far-side event source for the receiver control block: carrier samples,
 * mid-bit edges and demodulated data edges, one call per event.
 * Assumes the bench calls its tasks from one process synchronous to aclk.
 */
`timescale 1ns/100ps
module lfr_lf_src (
	output logic carrier_sample_valid,
	output logic carrier_sample_hit,
	output logic midbit_valid,
	output logic midbit_rising,
	output logic data_edge,
	output logic data_level,
	input wire logic aclk
);
	// Everything is quiet at start so nothing is seen before the first call.
	initial begin
		carrier_sample_valid = 1'b0;
		carrier_sample_hit = 1'b0;
		midbit_valid = 1'b0;
		midbit_rising = 1'b0;
		data_edge = 1'b0;
		data_level = 1'b0;
	end

	// Qualifiers flip once their strobe drops, so a stale value is never trusted.
	task automatic sample(input logic hit);
		@(posedge aclk);
		carrier_sample_valid <= 1'b1;
		carrier_sample_hit <= hit;
		@(posedge aclk);
		carrier_sample_valid <= 1'b0;
		carrier_sample_hit <= ~hit;
	endtask : sample

	// One mid-bit transition of the given direction.
	task automatic midbit(input logic rising);
		@(posedge aclk);
		midbit_valid <= 1'b1;
		midbit_rising <= rising;
		@(posedge aclk);
		midbit_valid <= 1'b0;
		midbit_rising <= ~rising;
	endtask : midbit

	// One data edge; the data level stays until the next edge changes it.
	task automatic edge_pulse(input logic level);
		@(posedge aclk);
		data_edge <= 1'b1;
		data_level <= level;
		@(posedge aclk);
		data_edge <= 1'b0;
	endtask : edge_pulse
endmodule : lfr_lf_src

// ### tb.sv
/*
 * Self-checking bench for the paged receiver control registers.
 * Assumes lfr_pkg and the event source model are compiled before it.
 */
`timescale 1ns/100ps
module tb import lfr_pkg::*;;
	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
		logic [1:0] wr;
		logic [7:0] rd;
		logic [1:0] rr;
	} lfr_row_s;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb, strb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, slicer_deadband;
	logic rx_data_mode, cs_valid, cs_hit, mb_valid, mb_rising, d_edge, d_level;
	logic [5:0] deadband_mv;
	logic filter_type_sel, filter_offset_sel, decoded_valid, decoded_bit;
	logic auto_zero_req, rx_chain_start, carrier_detect_flag, irq;
	logic [2:0] edge_gap_count;
	logic [5:0] mv [4] = '{DB_MV0, DB_MV1, DB_MV2, DB_MV3};
	lfr_row_s rows [6];
	int mismatches = 0, tests_run = 0, cycles = 0, starts = 0, azs = 0;

	lfr_ctrl_ba DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_data_mode(rx_data_mode),
		.carrier_sample_valid(cs_valid), .carrier_sample_hit(cs_hit), .midbit_valid(mb_valid),
		.midbit_rising(mb_rising), .data_edge(d_edge), .data_level(d_level),
		.slicer_deadband(slicer_deadband), .deadband_mv(deadband_mv),
		.filter_type_sel(filter_type_sel), .filter_offset_sel(filter_offset_sel),
		.edge_gap_count(edge_gap_count), .decoded_valid(decoded_valid),
		.decoded_bit(decoded_bit), .auto_zero_req(auto_zero_req),
		.rx_chain_start(rx_chain_start), .carrier_detect_flag(carrier_detect_flag), .irq(irq));

	lfr_lf_src u_src (.carrier_sample_valid(cs_valid), .carrier_sample_hit(cs_hit),
		.midbit_valid(mb_valid), .midbit_rising(mb_rising), .data_edge(d_edge),
		.data_level(d_level), .aclk(aclk));

	// A 40 ns period gives the 25 MHz system clock.
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Pulses are counted here so no one-cycle event is missed; the ceiling cuts off a hang.
	always @(posedge aclk) begin
		cycles++;
		if (rx_chain_start === 1'b1) starts++;
		if (auto_zero_req === 1'b1) azs++;
		if (cycles == 6000) begin
			mismatches++;
			results();
		end
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// Address and data go out together; each is dropped at its own handshake.
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= strb;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	// Main sequence: table of register accesses first, then the hand-written cases.
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		strb = 4'h1;
		rx_data_mode = 1'b0;
		rows = '{'{8'h90, 8'h3b, RESP_SLVERR, 8'h00, RESP_SLVERR},
			'{8'h98, 8'h01, RESP_OKAY, 8'h01, RESP_OKAY},
			'{8'h90, 8'h3e, RESP_OKAY, 8'h3e, RESP_OKAY},
			'{8'h94, 8'hfa, RESP_OKAY, 8'h0a, RESP_OKAY},
			'{8'h90, 8'hc6, RESP_OKAY, 8'hc6, RESP_OKAY},
			'{8'hfc, 8'h55, RESP_SLVERR, 8'h00, RESP_SLVERR}};
		cyc(3);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			axi_write(rows[i].a, rows[i].d, r);
			check(r, rows[i].wr);
			axi_read(rows[i].a, v, r);
			check(r, rows[i].rr);
			check(v, {24'h000000, rows[i].rd});
		end
		$display("test register table done");
		for (int c = 0; c < 4; c++) begin
			axi_write(8'h90, {c[1:0], c[1:0], 4'h6}, r);
			cyc(2);
			check(slicer_deadband, c[1:0]);
			check(deadband_mv, mv[c]);
			check({filter_type_sel, filter_offset_sel}, c[1:0]);
			check(edge_gap_count, 3'h6);
		end
		$display("test field decode done");
		@(posedge aclk);
		rx_data_mode <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			axi_write(8'h90, {4'hc, p[0], 3'h6}, r);
			for (int e = 0; e < 2; e++) begin
				u_src.midbit(e[0]);
				@(negedge aclk);
				check(decoded_valid, 1'b1);
				check(decoded_bit, e[0] ^ p[0]);
			end
		end
		@(posedge aclk);
		rx_data_mode <= 1'b0;
		u_src.midbit(1'b1);
		@(negedge aclk);
		check(decoded_valid, 1'b0);
		$display("test manchester done");
		// Target 2 needs three consecutive hits; the miss restarts the run.
		axi_write(8'h94, 8'h02, r);
		axi_write(8'h9c, 8'h03, r);
		starts = 0;
		u_src.sample(1'b1);
		u_src.sample(1'b1);
		u_src.sample(1'b0);
		u_src.sample(1'b1);
		u_src.sample(1'b1);
		cyc(4);
		check(carrier_detect_flag, 1'b0);
		u_src.sample(1'b1);
		cyc(4);
		check(carrier_detect_flag, 1'b1);
		check(starts, 1);
		axi_write(8'ha0, 8'h00, r);
		cyc(3);
		check(irq, 1'b0);
		axi_write(8'ha0, 8'h01, r);
		cyc(3);
		check(irq, 1'b1);
		axi_write(8'h9c, 8'h01, r);
		cyc(3);
		check(irq, 1'b0);
		axi_read(8'h9c, v, r);
		check(v[0], 1'b0);
		@(posedge aclk);
		rx_data_mode <= 1'b1;
		repeat (4) u_src.sample(1'b1);
		cyc(4);
		check(carrier_detect_flag, 1'b0);
		@(posedge aclk);
		rx_data_mode <= 1'b0;
		axi_write(8'h98, 8'h03, r);
		u_src.sample(1'b1);
		cyc(4);
		check(carrier_detect_flag, 1'b1);
		check(starts, 2);
		$display("test carrier done");
		// Gap 3 with plain triggering, then data-level high triggering.
		axi_write(8'h98, 8'h01, r);
		axi_write(8'h90, 8'hc3, r);
		@(posedge aclk);
		rx_data_mode <= 1'b1;
		azs = 0;
		repeat (2) u_src.edge_pulse(1'b1);
		cyc(3);
		check(azs, 0);
		u_src.edge_pulse(1'b0);
		cyc(3);
		check(azs, 1);
		axi_write(8'h98, {4'h0, AZS_HIGH, 2'h1}, r);
		repeat (4) u_src.edge_pulse(1'b0);
		cyc(3);
		check(azs, 1);
		u_src.edge_pulse(1'b1);
		cyc(3);
		check(azs, 2);
		$display("test auto-zero done");
		// Lane 0 strobe low: the write is answered but the register keeps its value.
		strb = 4'he;
		axi_write(8'h90, 8'h00, r);
		check(r, RESP_OKAY);
		strb = 4'h1;
		axi_read(8'h90, v, r);
		check(v, 32'h000000c3);
		$display("test strobe done");
		// Reset in mid-run closes the page and restores the defaults.
		@(posedge aclk);
		aresetn <= 1'b0;
		rx_data_mode <= 1'b0;
		cyc(3);
		aresetn <= 1'b1;
		@(negedge aclk);
		check({slicer_deadband, edge_gap_count}, 5'h1c);
		check({carrier_detect_flag, irq}, 2'h0);
		axi_read(8'h90, v, r);
		check(r, RESP_SLVERR);
		axi_write(8'h98, 8'h01, r);
		axi_read(8'h90, v, r);
		check(v, {24'h000000, FILT_RST});
		axi_read(8'h94, v, r);
		check(v, 32'h00000000);
		$display("test reset done");
		results();
	end
endmodule : tb
